// *** sfpi_flash_pins.sv ***
// How it works
// - select high: all data outputs tri-stated
// - internal busy cycle survives deselect
// - select low enables input and output
// - ignore commands until first select fall
// - single mode samples serial_in_line rising edge
// - single mode output changes on falling edge
// - dual/quad: rise samples, fall drives
// - quad transfers only with quad_lines_enable
// - enable set: guard/pause pins become data
// - guard and pause only in single/dual
// - guard pin with lock blocks status writes
// - protection from one sector to whole array
// - enable set disables write guard
// - paused: output off, clock and input ignored
// - pause release resumes where it stopped
// - enable set disables pause function
// - line three is pause or restart
// - pause starts/ends with clock low
// - function select 0 pause, 1 restart
// - restart low 1us aborts, resets state
// - clock modes 0 and 3 supported
//
// Local design decisions: the register addresses and the APB register port.
module sfpi_flash_pins
  import sfpi_pkg::*;
#(
  parameter int BUSY_CYCLES = SFPI_BUSY_CYC
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic selectN,
  input wire logic sclk,
  input wire logic [3:0] dataLineIn,
  output logic [3:0] dataLineOut,
  output logic [3:0] dataLineOe
);

  localparam logic [3:0] RESTART_CYC = 4'(SFPI_RESTART_CYC);
  localparam logic [SFPI_BUSY_W-1:0] BUSY_LOAD = SFPI_BUSY_W'(BUSY_CYCLES);
  localparam logic [SFPI_SECT_LOG2:0] SECT_ALL = (SFPI_SECT_LOG2 + 1)'(1 << SFPI_SECT_LOG2);

  sfpi_state_t s_r;
  sfpi_state_t s_nxt;

  logic [5:0] pinSync;
  logic csnS;
  logic sclkS;
  logic [3:0] ioS;

  sfpi_sync #(
    .W(6)
  ) u_sync (
    .mclk(mclk),
    .rstn(rstn),
    .d({selectN, sclk, dataLineIn}),
    .q(pinSync)
  );

  assign csnS = pinSync[5];
  assign sclkS = pinSync[4];
  assign ioS = pinSync[3:0];

  sfpi_width_t width;
  logic quadOk;
  logic laneOk;
  logic pauseFn;
  logic restartFn;
  logic guardBlocks;
  logic restartLow;
  logic sclkRise;
  logic sclkFall;
  logic active;
  logic [3:0] bitsIn;
  logic [3:0] step;
  logic [3:0] oeMask;
  logic [SFPI_SECT_LOG2:0] nSect;
  logic [SFPI_SECT_LOG2:0] firstSect;
  logic [SFPI_SECT_LOG2:0] lastSect;
  logic regionValid;
  logic [31:0] statusWord;
  logic apbSetup;
  logic apbAccess;
  logic apbWrite;
  logic addrOk;

  always_comb begin
    unique case (s_r.lane)
      SFPI_LANE_DUAL: width = SFPI_W2;
      SFPI_LANE_QUAD: width = SFPI_W4;
      default: width = SFPI_W1;
    endcase
  end

  // quad width needs the enable bit
  assign quadOk = s_r.qle;
  assign laneOk = (width != SFPI_W4) || quadOk;
  assign pauseFn = !s_r.qle && !s_r.pinFn;
  assign restartFn = !s_r.qle && s_r.pinFn;
  // guard only when line two is a pin
  assign guardBlocks = !s_r.qle && s_r.prot[SFPI_PROT_LOCK] && !ioS[2];
  assign restartLow = restartFn && !ioS[3];

  assign sclkRise = sclkS && !s_r.sclkPrev;
  assign sclkFall = !sclkS && s_r.sclkPrev;

  assign active = s_r.selected && s_r.armed && !s_r.paused && !restartLow && laneOk;

  always_comb begin
    unique case (width)
      SFPI_W1: begin
        bitsIn = {3'h0, ioS[0]};
        step = 4'h1;
        oeMask = 4'h2;
      end
      SFPI_W2: begin
        bitsIn = {2'h0, ioS[1:0]};
        step = 4'h2;
        oeMask = 4'h3;
      end
      SFPI_W4: begin
        bitsIn = ioS;
        step = 4'h4;
        oeMask = 4'hF;
      end
    endcase
  end

  always_comb begin
    logic [3:0] apf;
    logic [SFPI_SECT_LOG2:0] n;
    apf = s_r.prot[SFPI_PROT_APF_LO +: 4];
    n = '0;
    if (apf == 4'h0) begin
      n = '0;
    end else if (apf > 4'(SFPI_SECT_LOG2)) begin
      n = SECT_ALL;
    end else begin
      n = (SFPI_SECT_LOG2 + 1)'(1) << (apf - 4'h1);
    end
    // complement protects what the plain setting leaves open
    if (s_r.prot[SFPI_PROT_COMPL]) begin
      n = SECT_ALL - n;
    end
    nSect = n;
    regionValid = (n != '0);
    if (s_r.prot[SFPI_PROT_TOPBOT] ^ s_r.prot[SFPI_PROT_COMPL]) begin
      firstSect = '0;
      lastSect = n - (SFPI_SECT_LOG2 + 1)'(1);
    end else begin
      firstSect = SECT_ALL - n;
      lastSect = SECT_ALL - (SFPI_SECT_LOG2 + 1)'(1);
    end
  end

  always_comb begin
    statusWord = '0;
    statusWord[SFPI_ST_SEL] = s_r.selected;
    statusWord[SFPI_ST_ARMED] = s_r.armed;
    statusWord[SFPI_ST_PAUSED] = s_r.paused;
    statusWord[SFPI_ST_RESTART] = restartLow;
    statusWord[SFPI_ST_BUSY] = (s_r.busyCnt != '0);
    statusWord[SFPI_ST_RXFULL] = s_r.rxFull;
    statusWord[SFPI_ST_WPBLK] = guardBlocks;
    statusWord[SFPI_ST_REGION] = regionValid;
    statusWord[SFPI_ST_PAUSEFN] = pauseFn;
  end

  assign apbSetup = psel && !penable;
  assign apbAccess = psel && penable;
  assign apbWrite = apbAccess && pwrite;
  always_comb begin
    unique case (paddr)
      SFPI_OFF_CTRL, SFPI_OFF_PROT, SFPI_OFF_TXDATA, SFPI_OFF_RXDATA, SFPI_OFF_STATUS,
      SFPI_OFF_REGION: addrOk = 1'b1;
      default: addrOk = 1'b0;
    endcase
  end

  always_comb begin
    logic pauseWant;
    logic clkLowish;
    logic rxDone;
    logic [7:0] src;
    s_nxt = s_r;
    src = '0;
    pauseWant = 1'b0;
    clkLowish = 1'b0;
    rxDone = 1'b0;
    s_nxt.sclkPrev = sclkS;
    s_nxt.csnPrev = csnS;

    // register reads captured in the setup phase so data is flopped
    if (apbSetup) begin
      unique case (paddr)
        SFPI_OFF_CTRL: s_nxt.prdata = {26'h0, 1'b0, s_r.txDir, s_r.lane, s_r.pinFn, s_r.qle};
        SFPI_OFF_PROT: s_nxt.prdata = {25'h0, s_r.prot};
        SFPI_OFF_TXDATA: s_nxt.prdata = {24'h0, s_r.txHold};
        SFPI_OFF_RXDATA: s_nxt.prdata = {24'h0, s_r.rxByte};
        SFPI_OFF_STATUS: s_nxt.prdata = statusWord;
        SFPI_OFF_REGION: s_nxt.prdata = {2'h0, lastSect, 2'h0, firstSect};
        default: s_nxt.prdata = '0;
      endcase
    end

    // busy countdown ignores the select pin
    if (s_r.busyCnt != '0) begin
      s_nxt.busyCnt = s_r.busyCnt - SFPI_BUSY_W'(1);
    end

    if (apbWrite) begin
      unique case (paddr)
        SFPI_OFF_CTRL: begin
          s_nxt.qle = pwdata[SFPI_CTRL_QLE];
          s_nxt.pinFn = pwdata[SFPI_CTRL_RST];
          s_nxt.lane = pwdata[SFPI_CTRL_LANE_LO +: 2];
          s_nxt.txDir = pwdata[SFPI_CTRL_TXDIR];
          if (pwdata[SFPI_CTRL_BUSY]) begin
            s_nxt.busyCnt = BUSY_LOAD;
          end
        end
        SFPI_OFF_PROT: begin
          // guard pin with lock refuses the write
          if (!guardBlocks) begin
            s_nxt.prot = pwdata[6:0];
          end
        end
        SFPI_OFF_TXDATA: s_nxt.txHold = pwdata[7:0];
        default: begin
        end
      endcase
    end
    if (apbAccess && !pwrite && paddr == SFPI_OFF_RXDATA) begin
      s_nxt.rxFull = 1'b0;
    end

    // a falling select arms and selects
    if (!csnS && s_r.csnPrev) begin
      s_nxt.selected = 1'b1;
      s_nxt.armed = 1'b1;
      s_nxt.bitCnt = '0;
      s_nxt.paused = 1'b0;
    end
    if (csnS) begin
      s_nxt.selected = 1'b0;
      s_nxt.paused = 1'b0;
      s_nxt.bitCnt = '0;
    end

    // pause edges only with clock low
    pauseWant = pauseFn && !ioS[3];
    clkLowish = !sclkS || sclkFall;
    if (s_r.selected && (pauseWant != s_r.paused) && clkLowish) begin
      // shift state is frozen, not cleared
      s_nxt.paused = pauseWant;
    end

    if (active && !s_r.txDir && sclkRise) begin
      s_nxt.shiftIn = (s_r.shiftIn << step) | {4'h0, bitsIn};
      s_nxt.bitCnt = s_r.bitCnt + step;
      if (s_r.bitCnt + step >= 4'h8) begin
        rxDone = 1'b1;
        s_nxt.bitCnt = '0;
        s_nxt.rxByte = (s_r.shiftIn << step) | {4'h0, bitsIn};
      end
    end
    // set wins over the clearing read
    if (rxDone) begin
      s_nxt.rxFull = 1'b1;
    end

    if (active && s_r.txDir && sclkFall) begin
      src = (s_r.bitCnt == 4'h0) ? s_r.txHold : s_r.shiftOut;
      unique case (width)
        SFPI_W1: s_nxt.ioOut = {2'h0, src[7], 1'b0};
        SFPI_W2: s_nxt.ioOut = {2'h0, src[7:6]};
        SFPI_W4: s_nxt.ioOut = src[7:4];
      endcase
      s_nxt.shiftOut = src << step;
      s_nxt.bitCnt = (s_r.bitCnt + step >= 4'h8) ? 4'h0 : s_r.bitCnt + step;
    end

    // restart pin held low past the minimum
    if (restartLow) begin
      if (s_r.rstCnt < RESTART_CYC) begin
        s_nxt.rstCnt = s_r.rstCnt + 4'h1;
      end else begin
        s_nxt.rstDone = 1'b1;
      end
    end else begin
      s_nxt.rstCnt = '0;
      s_nxt.rstDone = 1'b0;
    end
    if (s_nxt.rstDone) begin
      // aborts any running cycle; volatile state back to power-on
      s_nxt.busyCnt = '0;
      s_nxt.armed = 1'b0;
      s_nxt.selected = 1'b0;
      s_nxt.paused = 1'b0;
      s_nxt.bitCnt = '0;
      s_nxt.shiftIn = '0;
      s_nxt.shiftOut = '0;
      s_nxt.ioOut = '0;
      s_nxt.txDir = 1'b0;
      s_nxt.lane = SFPI_RST_LANE;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s_r <= '0;
      s_r.qle <= SFPI_RST_QLE;
      s_r.pinFn <= SFPI_RST_PINFN;
      s_r.lane <= SFPI_RST_LANE;
      s_r.prot <= SFPI_RST_PROT;
      s_r.sclkPrev <= 1'b0;
      s_r.csnPrev <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // zero-wait apb slave; data was captured during setup
  assign pready = apbAccess;
  assign pslverr = apbAccess && !addrOk;
  assign prdata = s_r.prdata;

  assign dataLineOut = s_r.ioOut;
  assign dataLineOe = (active && s_r.txDir && !csnS) ? oeMask : 4'h0;

endmodule : sfpi_flash_pins

// *** sfpi_flash_pins_checker.sv ***
module sfpi_flash_pins_checker
  import sfpi_pkg::*;
#(
  parameter int BUSY_CYCLES = SFPI_BUSY_CYC
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic selectN,
  input wire logic sclk,
  input wire logic [3:0] dataLineIn,
  input wire logic [3:0] dataLineOut,
  input wire logic [3:0] dataLineOe
);
  logic [4:0] ctl_r;
  logic sawSel_r;
  logic sclkD_r;
  logic [3:0] fallAge_r;
  logic [4:0] rstLow_r;
  logic acc;
  logic stRd;
  assign acc = psel && penable;
  assign stRd = acc && !pwrite && paddr == SFPI_OFF_STATUS;
  // shadow of the control bits, seen only through bus writes
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ctl_r <= 5'h00;
      sawSel_r <= 1'b0;
      sclkD_r <= 1'b0;
      fallAge_r <= 4'hF;
      rstLow_r <= 5'h00;
    end else begin
      ctl_r <= (acc && pwrite && paddr == SFPI_OFF_CTRL) ? pwdata[4:0] : ctl_r;
      sawSel_r <= sawSel_r | !selectN;
      sclkD_r <= sclk;
      fallAge_r <= (sclkD_r && !sclk) ? 4'h0 : fallAge_r + {3'h0, fallAge_r != 4'hF};
      rstLow_r <= (ctl_r[1] && !ctl_r[0] && !dataLineIn[3]) ?
        rstLow_r + {4'h0, rstLow_r != 5'h1F} : 5'h00;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  AST_DESEL_HIZ: assert property (selectN [*4] |-> dataLineOe == 4'h0)
    else $error("lines driven while deselected");
  AST_OUT_FALL: assert property ($changed(dataLineOut) && !selectN && !ctl_r[1]
    |-> fallAge_r < 4'h7) else $error("output moved away from a clock fall");
  AST_QUAD_ONLY: assert property (dataLineOe[3:2] != 2'h0
    |-> ctl_r[0] && ctl_r[3:2] == SFPI_LANE_QUAD) else $error("upper lines driven");
  AST_SINGLE_LINE: assert property (ctl_r[3:2] == SFPI_LANE_SINGLE
    |-> !dataLineOe[0] && dataLineOe[3:2] == 2'h0) else $error("single mode lines wrong");
  AST_QUAD_FN_OFF: assert property (stRd && ctl_r[0]
    |-> !prdata[SFPI_ST_PAUSEFN] && !prdata[SFPI_ST_WPBLK]) else $error("pin fn in quad");
  AST_ARM_FIRST: assert property (stRd && !sawSel_r |-> !prdata[SFPI_ST_ARMED])
    else $error("armed without select fall");
  AST_PAUSE_HIZ: assert property ((!selectN && !sclk && !dataLineIn[3]
    && ctl_r[1:0] == 2'h0) [*6] |-> dataLineOe == 4'h0) else $error("driven while paused");
  AST_RESTART: assert property (stRd && rstLow_r > 5'd16
    |-> !prdata[SFPI_ST_BUSY] && !prdata[SFPI_ST_ARMED]) else $error("restart not taken");
  cover property (stRd && prdata[SFPI_ST_PAUSED]);
  cover property (dataLineOe == 4'hF);
  cover property (stRd && rstLow_r > 5'd16);
endmodule : sfpi_flash_pins_checker

bind sfpi_flash_pins sfpi_flash_pins_checker #(.BUSY_CYCLES(BUSY_CYCLES))
  u_sfpi_flash_pins_checker (.*);

// *** sfpi_host_model.sv ***
module sfpi_host_model (
  input wire logic mclk,
  input wire logic [3:0] dataLineOut,
  input wire logic [3:0] dataLineOe,
  output logic selectN,
  output logic sclk,
  output logic [3:0] dataLineIn
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] hostOut = 4'hF;
  logic [3:0] hostOe = 4'hF;
  logic [3:0] lastIn = 4'h0;
  initial selectN = 1'b1;
  initial sclk = 1'b0;
  // released lines flip every cycle, never a stale value
  always @(posedge mclk) lastIn <= dataLineIn;
  assign dataLineIn = (dataLineOe & dataLineOut) |
    (~dataLineOe & ((hostOe & hostOut) | (~hostOe & ~lastIn)));
  task automatic hold(input int n);
    repeat (n) @(posedge mclk);
  endtask : hold
  task automatic sel(input logic idle, input logic [3:0] v);
    @(posedge mclk);
    sclk <= idle;
    hostOut <= v;
    hostOe <= 4'hF;
    hold(4);
    selectN <= 1'b0;
    hold(4);
  endtask : sel
  task automatic desel(input logic idle);
    @(posedge mclk);
    sclk <= idle;
    hold(4);
    selectN <= 1'b1;
    hold(4);
  endtask : desel
  // change on fall, sample in high
  task automatic bit1(input logic [3:0] v, input logic [3:0] oe, output logic [3:0] got);
    @(posedge mclk);
    sclk <= 1'b0;
    hostOut <= v;
    hostOe <= oe;
    hold(4);
    sclk <= 1'b1;
    hold(3);
    got = dataLineIn;
  endtask : bit1
  // pin levels held with clock low
  task automatic park(input logic [3:0] v, input int n);
    @(posedge mclk);
    sclk <= 1'b0;
    hostOut <= v;
    hostOe <= 4'hF;
    hold(n);
  endtask : park
endmodule : sfpi_host_model

// *** sfpi_pkg.sv ***
package sfpi_pkg;

  // register byte offsets on the apb slave
  localparam logic [7:0] SFPI_OFF_CTRL = 8'h00;
  localparam logic [7:0] SFPI_OFF_PROT = 8'h04;
  localparam logic [7:0] SFPI_OFF_TXDATA = 8'h08;
  localparam logic [7:0] SFPI_OFF_RXDATA = 8'h0C;
  localparam logic [7:0] SFPI_OFF_STATUS = 8'h10;
  localparam logic [7:0] SFPI_OFF_REGION = 8'h14;

  // control register fields
  localparam int SFPI_CTRL_QLE = 0;
  localparam int SFPI_CTRL_RST = 1;
  localparam int SFPI_CTRL_LANE_LO = 2;
  localparam int SFPI_CTRL_TXDIR = 4;
  localparam int SFPI_CTRL_BUSY = 5;

  // protect register fields
  localparam int SFPI_PROT_APF_LO = 0;
  localparam int SFPI_PROT_TOPBOT = 4;
  localparam int SFPI_PROT_COMPL = 5;
  localparam int SFPI_PROT_LOCK = 6;

  // status register fields
  localparam int SFPI_ST_SEL = 0;
  localparam int SFPI_ST_ARMED = 1;
  localparam int SFPI_ST_PAUSED = 2;
  localparam int SFPI_ST_RESTART = 3;
  localparam int SFPI_ST_BUSY = 4;
  localparam int SFPI_ST_RXFULL = 5;
  localparam int SFPI_ST_WPBLK = 6;
  localparam int SFPI_ST_REGION = 7;
  localparam int SFPI_ST_PAUSEFN = 8;

  // values after reset
  localparam logic SFPI_RST_QLE = 1'b0;
  localparam logic SFPI_RST_PINFN = 1'b0;
  localparam logic [1:0] SFPI_RST_LANE = 2'h0;
  localparam logic [6:0] SFPI_RST_PROT = 7'h00;

  // lane width codes in the control register
  localparam logic [1:0] SFPI_LANE_SINGLE = 2'h0;
  localparam logic [1:0] SFPI_LANE_DUAL = 2'h1;
  localparam logic [1:0] SFPI_LANE_QUAD = 2'h2;

  // timing
  localparam int SFPI_CLK_PERIOD_NS = 100;
  localparam int SFPI_RESTART_MIN_NS = 1000;
  localparam int SFPI_RESTART_CYC =
    (SFPI_RESTART_MIN_NS + SFPI_CLK_PERIOD_NS - 1) / SFPI_CLK_PERIOD_NS;
  localparam int SFPI_BUSY_CYC = 64;

  localparam int SFPI_SECT_LOG2 = 13;
  localparam int SFPI_BUSY_W = 16;

  typedef enum logic [1:0] {
    SFPI_W1,
    SFPI_W2,
    SFPI_W4
  } sfpi_width_t;

  typedef struct packed {
    logic qle;
    logic pinFn;
    logic [1:0] lane;
    logic txDir;
    logic [6:0] prot;
    logic [7:0] txHold;
    logic [7:0] rxByte;
    logic rxFull;
    logic [7:0] shiftIn;
    logic [7:0] shiftOut;
    logic [3:0] bitCnt;
    logic selected;
    logic armed;
    logic paused;
    logic [SFPI_BUSY_W-1:0] busyCnt;
    logic [3:0] rstCnt;
    logic rstDone;
    logic sclkPrev;
    logic csnPrev;
    logic [3:0] ioOut;
    logic [31:0] prdata;
  } sfpi_state_t;

endpackage : sfpi_pkg

// *** sfpi_sync.sv ***
module sfpi_sync #(
  parameter int W = 1
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
  } sfpi_sync_t;

  sfpi_sync_t s_r;
  sfpi_sync_t s_nxt;

  // first stage feeds only the second
  always_comb begin
    s_nxt.stage1 = d;
    s_nxt.stage2 = s_r.stage1;
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign q = s_r.stage2;

endmodule : sfpi_sync

// *** tb_serial_flash_pin_interface.sv ***
module tb_serial_flash_pin_interface
  import sfpi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic selectN;
  logic sclk;
  logic [3:0] dataLineIn;
  logic [3:0] dataLineOut;
  logic [3:0] dataLineOe;
  logic errSeen;
  int failCount = 0;
  int totalChecks = 0;
  always #50 mclk = ~mclk;
  // long busy so a deselect lands inside it
  sfpi_flash_pins #(.BUSY_CYCLES(200)) u_sfpi_flash_pins (.*);
  sfpi_host_model u_sfpi_host_model (.*);
  task automatic chk(input string s, input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp) begin
      failCount++;
      $display("wrong value %s expected %h seen %h", s, exp, got);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    q = prdata;
    errSeen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask : wr
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                      input string s);
    logic [31:0] q;
    apb(1'b0, a, 32'h0, q);
    chk(s, q & m, e);
  endtask : rchk
  task automatic tIdle();
    logic [3:0] g;
    rchk(SFPI_OFF_CTRL, 32'h3F, 32'h0, "ctrl");
    rchk(SFPI_OFF_PROT, 32'h7F, 32'h0, "prot");
    repeat (8) u_sfpi_host_model.bit1(4'hF, 4'hF, g);
    rchk(SFPI_OFF_STATUS, 32'h123, 32'h100, "idle status");
    rchk(8'h18, 32'hFFFFFFFF, 32'h0, "unmapped");
    chk("slverr", {31'h0, errSeen}, 32'h1);
  endtask : tIdle
  task automatic rxByte(input logic [4:0] c, input logic [7:0] b, input logic [7:0] e);
    logic [3:0] g;
    int w;
    wr(SFPI_OFF_CTRL, {27'h0, c});
    w = c[3:2] == SFPI_LANE_QUAD ? 4 : c[3:2] == SFPI_LANE_DUAL ? 2 : 1;
    u_sfpi_host_model.sel(1'b0, 4'hF);
    for (int i = 8; i > 0; i -= w)
      u_sfpi_host_model.bit1(w == 4 ? b[i-1 -: 4] : w == 2 ? {2'h3, b[i-1 -: 2]} :
                             {3'h7, b[i-1]}, 4'hF, g);
    u_sfpi_host_model.desel(1'b0);
    rchk(SFPI_OFF_RXDATA, 32'hFF, {24'h0, e}, "rx byte");
  endtask : rxByte
  task automatic txByte(input logic [4:0] c, input logic [7:0] b);
    logic [3:0] g;
    logic [7:0] q;
    int w;
    wr(SFPI_OFF_CTRL, {27'h0, c});
    wr(SFPI_OFF_TXDATA, {24'h0, b});
    w = c[3:2] == SFPI_LANE_QUAD ? 4 : c[3:2] == SFPI_LANE_DUAL ? 2 : 1;
    u_sfpi_host_model.sel(1'b1, 4'hF);
    for (int i = 0; i < 8; i += w) begin
      u_sfpi_host_model.bit1(4'hF, w == 4 ? 4'h0 : w == 2 ? 4'hC : 4'hD, g);
      q = w == 4 ? {q[3:0], g} : w == 2 ? {q[5:0], g[1:0]} : {q[6:0], g[1]};
    end
    chk("tx oe", {28'h0, dataLineOe}, w == 4 ? 32'hF : w == 2 ? 32'h3 : 32'h2);
    // pause while the device drives: output must let go
    if (w == 1) begin
      u_sfpi_host_model.park(4'h5, 8);
      chk("paused oe", {28'h0, dataLineOe}, 32'h0);
    end
    u_sfpi_host_model.desel(1'b1);
    chk("tx byte", {24'h0, q}, {24'h0, b});
    chk("idle oe", {28'h0, dataLineOe}, 32'h0);
  endtask : txByte
  task automatic tPause();
    logic [3:0] g;
    logic [7:0] p;
    p = 8'hB2;
    wr(SFPI_OFF_CTRL, 32'h0);
    u_sfpi_host_model.sel(1'b0, 4'hF);
    for (int i = 7; i > 3; i--)
      u_sfpi_host_model.bit1({3'h7, p[i]}, 4'hF, g);
    u_sfpi_host_model.park(4'h6, 8);
    rchk(SFPI_OFF_STATUS, 32'h4, 32'h4, "paused");
    repeat (2) u_sfpi_host_model.bit1(4'h6, 4'hF, g);
    for (int i = 3; i >= 0; i--)
      u_sfpi_host_model.bit1({3'h7, p[i]}, 4'hF, g);
    u_sfpi_host_model.desel(1'b0);
    rchk(SFPI_OFF_RXDATA, 32'hFF, {24'h0, p}, "resumed byte");
  endtask : tPause
  task automatic tGuard();
    wr(SFPI_OFF_CTRL, 32'h0);
    wr(SFPI_OFF_PROT, 32'h43);
    u_sfpi_host_model.park(4'hB, 4);
    wr(SFPI_OFF_PROT, 32'h0F);
    rchk(SFPI_OFF_PROT, 32'h7F, 32'h43, "guarded prot");
    rchk(SFPI_OFF_STATUS, 32'hC0, 32'hC0, "guard status");
    rchk(SFPI_OFF_REGION, 32'hFFFFFFFF, 32'h1FFF1FFC, "top region");
    wr(SFPI_OFF_CTRL, 32'h1);
    wr(SFPI_OFF_PROT, 32'h0F);
    rchk(SFPI_OFF_STATUS, 32'h140, 32'h0, "pin fns off");
    rchk(SFPI_OFF_REGION, 32'hFFFFFFFF, 32'h1FFF0000, "whole array");
    u_sfpi_host_model.park(4'hF, 4);
  endtask : tGuard
  task automatic tRestart();
    wr(SFPI_OFF_CTRL, 32'h22);
    u_sfpi_host_model.sel(1'b0, 4'hF);
    u_sfpi_host_model.desel(1'b0);
    rchk(SFPI_OFF_STATUS, 32'h112, 32'h12, "busy kept");
    u_sfpi_host_model.park(4'h7, 4);
    u_sfpi_host_model.park(4'hF, 4);
    rchk(SFPI_OFF_STATUS, 32'h12, 32'h12, "short pulse");
    u_sfpi_host_model.park(4'h7, 20);
    rchk(SFPI_OFF_STATUS, 32'h1A, 32'h08, "restarted");
    u_sfpi_host_model.park(4'hF, 4);
  endtask : tRestart
  task automatic giveVerdict();
    if (failCount == 0 && totalChecks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : giveVerdict
  initial begin
    repeat (10) @(posedge mclk);
    rstn <= 1'b1;
    tIdle();
    rxByte(5'h00, 8'hA5, 8'hA5);
    rxByte(5'h04, 8'h3C, 8'h3C);
    rxByte(5'h08, 8'h5A, 8'h3C);
    rxByte(5'h09, 8'hC3, 8'hC3);
    txByte(5'h10, 8'h96);
    txByte(5'h14, 8'h69);
    txByte(5'h19, 8'hA7);
    tPause();
    tGuard();
    tRestart();
    giveVerdict();
  end
  initial begin
    repeat (20000) @(posedge mclk);
    failCount++;
    giveVerdict();
  end
endmodule : tb_serial_flash_pin_interface
